// >>> design/cph_params.svh
/*
 Constants for the parallel host port: strap encodings, access timing
 and reset levels. Assumes inclusion by the port package and top module.
*/
`ifndef CPH_PARAMS_SVH
`define CPH_PARAMS_SVH

// ==================
// Straps, sizes, timing and reset value
`define CPH_STYLE_STROBES    1'b0
`define CPH_STYLE_DIRECTION  1'b1
`define CPH_MUX_ON           1'b1
`define CPH_ADDR_W           8
`define CPH_DATA_W           8
`define CPH_ACK_NS           16
`define CPH_CLK_NS           8
`define CPH_ACK_CYC          ((`CPH_ACK_NS + `CPH_CLK_NS - 1) / `CPH_CLK_NS)
// Edges the strap synchroniser needs before it shows the pin
`define CPH_STRAP_CYC        2
`define CPH_MEM_DEPTH        256
`define CPH_DATA_RST         8'h00

`endif

// >>> design/cph_pkg.sv
/*
 Types for the parallel host port. Assumes cph_params.svh is present.
*/
`include "cph_params.svh"
// ==================
// Types
package cph_pkg;
   typedef enum logic [2:0] {
      CPH_IDLE  = 3'b000,
      CPH_READ  = 3'b001,
      CPH_WRITE = 3'b010,
      CPH_ACK   = 3'b011,
      CPH_DONE  = 3'b100
   } cph_state_t;
endpackage : cph_pkg

// >>> design/cph_mem.sv
/*
 Location store behind the host port: 256 bytes, registered read data.
 Assumes one clock shared with the port logic.
*/
`timescale 1ns/1ps
`include "cph_params.svh"

// ==================
// Location store
module cph_mem (
   input  wire logic       mclk,
   input  wire logic       we,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] store [0:`CPH_MEM_DEPTH-1];

   always_ff @(posedge mclk) begin
      if (we) begin
         store[addr] <= wdata;
      end
      rdata <= store[addr];
   end
endmodule : cph_mem

// >>> design/cph_host_port.sv
/*
 Pin-level 8-bit host port of the device: two bus styles, multiplexed or
 plain addressing, access handshake and interrupt line. Assumes all host
 pins are asynchronous to mclk; device events arrive on dev_event.
*/
`timescale 1ns/1ps
`include "cph_params.svh"

module cph_host_port (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic [7:1] host_addr_hi,
   input  wire logic       host_a0_ale,
   input  wire logic [7:0] host_data_in,
   output logic      [7:0] host_data_out,
   output logic            host_data_oe_n,
   input  wire logic       host_sel_n,
   input  wire logic       host_write_or_data_strobe_n,
   input  wire logic       host_read_or_dir,
   input  wire logic       style_strap,
   input  wire logic       mux_strap,
   input  wire logic       dev_event,
   output logic            host_irq,
   output logic            host_done_out,
   output logic            host_done_oe_n
);
   // ==================
   // State
   // All flops of the port outside the location store live in this one record
   typedef struct packed {
      logic [1:0]           s_sel, s_st, s_rd, s_ale, s_style, s_mux;
      logic [7:1]           s_ahi1, s_ahi2;
      logic [7:0]           s_d1, s_d2;
      logic [1:0]           strap_cnt;
      logic                 style, mux, straps_ok;
      logic [7:0]           ale_addr, addr, wdata;
      logic                 mem_we;
      logic [1:0]           wait_cnt;
      cph_pkg::cph_state_t  st;
      logic [7:0]           dout;
      logic                 d_oe_n, irq, done, done_oe_n;
   } cph_state_s_t;

   cph_state_s_t s_reg, s_next;
   logic [7:0]   mem_rdata;

   // ==================
   // Strobe decode
   // Returns {read, write} active for the held bus style
   function automatic logic [1:0] cph_decode(input logic style,
                                             input logic st_n,
                                             input logic rd);
      logic [1:0] r;
      r = 2'b00;
      if (style == `CPH_STYLE_STROBES) begin
         r = {!rd, !st_n};
      end else if (!st_n) begin
         r = {rd, !rd};
      end
      return r;
   endfunction : cph_decode

   // ==================
   // Location store
   cph_mem cph_mem_inst (
      .mclk  (mclk),
      .we    (s_reg.mem_we),
      .addr  (s_reg.addr),
      .wdata (s_reg.wdata),
      .rdata (mem_rdata)
   );

   // ==================
   // Next state
   always_comb begin
      logic [1:0] rw;
      logic       sel_ok;
      logic       ale_now;
      logic [7:0] a_full;
      rw      = 2'b00;
      sel_ok  = 1'b0;
      ale_now = 1'b0;
      a_full  = 8'h00;
      s_next  = s_reg;

      // ==================
      // Pin synchronisers
      // Two stages each; only stage two is read below
      s_next.s_sel   = {s_reg.s_sel[0], host_sel_n};
      s_next.s_st    = {s_reg.s_st[0], host_write_or_data_strobe_n};
      s_next.s_rd    = {s_reg.s_rd[0], host_read_or_dir};
      s_next.s_ale   = {s_reg.s_ale[0], host_a0_ale};
      s_next.s_style = {s_reg.s_style[0], style_strap};
      s_next.s_mux   = {s_reg.s_mux[0], mux_strap};
      s_next.s_ahi1  = host_addr_hi;
      s_next.s_ahi2  = s_reg.s_ahi1;
      s_next.s_d1    = host_data_in;
      s_next.s_d2    = s_reg.s_d1;
      s_next.mem_we  = 1'b0;

      // ==================
      // Strap capture
      // Straps are held once the synchroniser has filled after reset;
      // taking them earlier would see the flops' reset value instead
      if (!s_reg.straps_ok) begin
         if (s_reg.strap_cnt == 2'(`CPH_STRAP_CYC)) begin
            s_next.style     = s_reg.s_style[1];
            s_next.mux       = s_reg.s_mux[1];
            s_next.straps_ok = 1'b1;
         end else begin
            s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
         end
      end

      // ==================
      // Address
      sel_ok = !s_reg.s_sel[1];
      rw     = cph_decode(s_reg.style, s_reg.s_st[1], s_reg.s_rd[1]);
      // Capture the whole address byte while latch enable is high and selected in multiplexed mode
      ale_now = (s_reg.mux == `CPH_MUX_ON) && s_reg.s_ale[1]
                && sel_ok;
      if (ale_now) begin
         s_next.ale_addr = s_reg.s_d2;
      end
      if (s_reg.mux == `CPH_MUX_ON) begin
         a_full = s_reg.ale_addr;
      end else begin
         a_full = {s_reg.s_ahi2, s_reg.s_ale[1]};
      end

      // ==================
      // Access sequencer
      case (s_reg.st)
         cph_pkg::CPH_IDLE: begin
            if (s_reg.straps_ok && sel_ok && rw[1]) begin
               s_next.addr     = a_full;
               s_next.wait_cnt = 2'(`CPH_ACK_CYC);
               s_next.st       = cph_pkg::CPH_READ;
            end else if (s_reg.straps_ok && sel_ok && rw[0]) begin
               s_next.addr     = a_full;
               s_next.st       = cph_pkg::CPH_WRITE;
            end
         end
         cph_pkg::CPH_READ: begin
            // Memory read data is registered; wait before presenting
            if (s_reg.wait_cnt != 2'h0) begin
               s_next.wait_cnt = s_reg.wait_cnt - 2'h1;
            end else begin
               s_next.dout   = mem_rdata;
               s_next.d_oe_n = 1'b0;
               s_next.st     = cph_pkg::CPH_ACK;
            end
         end
         cph_pkg::CPH_WRITE: begin
            // Data taken one cycle after the strobe was seen settled
            s_next.wdata  = s_reg.s_d2;
            s_next.mem_we = 1'b1;
            s_next.st     = cph_pkg::CPH_ACK;
         end
         cph_pkg::CPH_ACK: begin
            s_next.done      = (s_reg.style == `CPH_STYLE_STROBES);
            s_next.done_oe_n = 1'b0;
            s_next.st        = cph_pkg::CPH_DONE;
         end
         cph_pkg::CPH_DONE: begin
            // Held until the host lets go of its strobe or select
            if (!sel_ok || rw == 2'b00) begin
               s_next.d_oe_n    = 1'b1;
               s_next.done_oe_n = 1'b1;
               s_next.st        = cph_pkg::CPH_IDLE;
            end
         end
         default: begin
            s_next.st = cph_pkg::CPH_IDLE;
         end
      endcase

      // ==================
      // Interrupt
      // Level follows the held style; before the straps are held it
      // shows the inactive level of the synchronised style strap.
      // Reset can only load a constant, so the line reads low until
      // then, which is the active level in direction style.
      if (s_reg.straps_ok) begin
         s_next.irq = (s_reg.style == `CPH_STYLE_STROBES)
                      ? dev_event : !dev_event;
      end else begin
         s_next.irq = s_reg.s_style[1];
      end
   end

   // ==================
   // Registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg           <= '0;
         // Active-low pins idle high; a zero here looks like an access
         s_reg.s_sel     <= 2'b11;
         s_reg.s_st      <= 2'b11;
         s_reg.s_rd      <= 2'b11;
         s_reg.d_oe_n    <= 1'b1;
         s_reg.done_oe_n <= 1'b1;
         s_reg.st        <= cph_pkg::CPH_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==================
   // Outputs
   assign host_data_out  = s_reg.dout;
   assign host_data_oe_n = s_reg.d_oe_n;
   assign host_irq       = s_reg.irq;
   assign host_done_out  = s_reg.done;
   assign host_done_oe_n = s_reg.done_oe_n;
endmodule : cph_host_port

// >>> dv/cph_host_port_chk.sv
/* Port checker for cph_host_port, bound to it.
   Assumes straps stay steady while reset is low. */
`timescale 1ns/1ps
// ==================
// Checker
module cph_host_port_chk (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic host_sel_n,
   input wire logic host_write_or_data_strobe_n,
   input wire logic host_read_or_dir,
   input wire logic style_strap,
   input wire logic dev_event,
   input wire logic host_irq,
   input wire logic host_data_oe_n,
   input wire logic host_done_out,
   input wire logic host_done_oe_n
);
   wire ws  = host_write_or_data_strobe_n;
   wire rr  = host_read_or_dir;
   wire st  = style_strap;
   wire sel = !host_sel_n;
   wire doe = host_data_oe_n;
   wire koe = host_done_oe_n;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   rst_release_a: assert property ($fell(sys_rst) |-> doe && koe)
      else $error("driven at reset release");
   sel_ignore_a: assert property (!sel [*5] |-> doe && koe)
      else $error("answer while deselected");
   data_then_done_a: assert property ($fell(doe) |=> $fell(koe))
      else $error("done not after read data");
   irq_level_a: assert property ($rose(dev_event) |=> host_irq != st)
      else $error("irq polarity");
   done_level_a: assert property (!koe |-> host_done_out == !st)
      else $error("done polarity");
   write_quiet_a: assert property ($fell(ws) && sel && !(st && rr)
      |-> doe throughout ##[2:8] !koe) else $error("write answer");
   read_strobe_a: assert property ($fell(rr) && sel && !st
      |-> ##[3:8] !doe) else $error("read enable answer");
   read_dir_a: assert property ($fell(ws) && sel && st && rr
      |-> ##[3:8] !doe) else $error("read strobe answer");
   cover property ($fell(doe));
   cover property (!koe && st);
   cover property ($rose(host_irq));
endmodule : cph_host_port_chk
bind cph_host_port cph_host_port_chk cph_host_port_chk_inst (
   .mclk                        (mclk),
   .sys_rst                     (sys_rst),
   .host_sel_n                  (host_sel_n),
   .host_write_or_data_strobe_n (host_write_or_data_strobe_n),
   .host_read_or_dir            (host_read_or_dir),
   .style_strap                 (style_strap),
   .dev_event                   (dev_event),
   .host_irq                    (host_irq),
   .host_data_oe_n              (host_data_oe_n),
   .host_done_out               (host_done_out),
   .host_done_oe_n              (host_done_oe_n)
);

// >>> dv/cph_host_model.sv
/* Host processor model: strobes, address and the shared data bus.
   Assumes the straps are steady while it runs accesses. */
`timescale 1ns/1ps
// ==================
// Host model
module cph_host_model (
   input  wire logic       mclk,
   input  wire logic       style_strap,
   input  wire logic       mux_strap,
   input  wire logic [7:0] host_data_out,
   input  wire logic       host_data_oe_n,
   input  wire logic       host_done_out,
   input  wire logic       host_done_oe_n,
   output logic      [7:1] host_addr_hi,
   output logic            host_a0_ale,
   output logic      [7:0] host_data_in,
   output logic            host_sel_n,
   output logic            host_write_or_data_strobe_n,
   output logic            host_read_or_dir
);
   logic       drv = 1'b0;
   logic [7:0] hv = 8'h00;
   // Released bus shows the inverse of the last value, never a stale copy
   assign host_data_in = !host_data_oe_n ? host_data_out : drv ? hv : ~hv;
   initial host_addr_hi = 7'h00;
   initial host_a0_ale = 1'b0;
   initial host_sel_n = 1'b1;
   initial host_write_or_data_strobe_n = 1'b1;
   initial host_read_or_dir = 1'b1;
   task automatic acc(input logic w, input logic s, input logic [7:0] a,
      input logic [7:0] wd, output logic [7:0] rd, output logic dn);
      @(negedge mclk);
      host_addr_hi = a[7:1];
      host_sel_n = s;
      // Address phase only when multiplexed; no pin is set twice at once
      if (mux_strap) begin
         host_a0_ale = 1'b1;
         drv = 1'b1;
         hv = a;
         repeat (4) @(negedge mclk);
      end
      host_a0_ale = !mux_strap & a[0];
      drv = w;
      hv = wd;
      host_read_or_dir = style_strap ? !w : w;
      host_write_or_data_strobe_n = !(style_strap | w);
      for (int n = 0; n < 20 && host_done_oe_n; n++) @(negedge mclk);
      rd = host_data_in;
      dn = host_done_oe_n ? 1'bz : host_done_out;
      host_write_or_data_strobe_n = 1'b1;
      host_read_or_dir = 1'b1;
      host_sel_n = 1'b1;
      drv = 1'b0;
      for (int n = 0; n < 20 && !(host_data_oe_n && host_done_oe_n); n++)
         @(negedge mclk);
      repeat (3) @(negedge mclk);
   endtask : acc
endmodule : cph_host_model

// >>> dv/tb_cph_host_port.sv
/* Bench for cph_host_port: every strap setting, host accesses by model.
   Assumes the model and the bound checker are compiled with it. */
`timescale 1ns/1ps
// ==================
// Bench
module tb_cph_host_port;
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:1] host_addr_hi;
   logic       host_a0_ale;
   logic [7:0] host_data_in, host_data_out, r;
   logic       host_data_oe_n, host_sel_n, host_write_or_data_strobe_n;
   logic       host_read_or_dir, style_strap = 1'b0, mux_strap = 1'b0;
   logic       dev_event = 1'b0, host_irq, host_done_out, host_done_oe_n, dn;
   int         error_cnt = 0;
   int         checks = 0;
   cph_host_port cph_host_port_inst (.*);
   cph_host_model cph_host_model_inst (.*);
   always #4 mclk = ~mclk;
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   task automatic t_reset(input logic st, input logic mx);
      sys_rst = 1'b1;
      style_strap = st;
      mux_strap = mx;
      repeat (8) @(negedge mclk);
      chk({host_data_oe_n, host_done_oe_n}, 8'h03);
      sys_rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk(host_irq, st);
      $display("reset test style=%0d mux=%0d done", st, mx);
   endtask : t_reset
   task automatic t_rw(input logic [7:0] a, input logic [7:0] d);
      cph_host_model_inst.acc(1'b1, 1'b0, a, d, r, dn);
      chk(dn, !style_strap);
      cph_host_model_inst.acc(1'b1, 1'b0, ~a, ~d, r, dn);
      cph_host_model_inst.acc(1'b0, 1'b0, a, 8'h00, r, dn);
      chk(r, d);
      chk(dn, !style_strap);
      cph_host_model_inst.acc(1'b0, 1'b0, ~a, 8'h00, r, dn);
      chk(r, ~d);
      chk({host_data_oe_n, host_done_oe_n}, 8'h03);
      $display("read/write test at %h done", a);
   endtask : t_rw
   task automatic t_sel();
      cph_host_model_inst.acc(1'b1, 1'b1, 8'h01, 8'hff, r, dn);
      chk(dn, 1'bz);
      cph_host_model_inst.acc(1'b0, 1'b0, 8'h01, 8'h00, r, dn);
      chk(r, 8'h3c);
      $display("chip select test done");
   endtask : t_sel
   task automatic t_irq();
      dev_event = 1'b1;
      repeat (2) @(negedge mclk);
      chk(host_irq, !style_strap);
      dev_event = 1'b0;
      repeat (2) @(negedge mclk);
      chk(host_irq, style_strap);
      $display("interrupt test done");
   endtask : t_irq
   initial begin
      t_reset(1'b0, 1'b0);
      t_rw(8'h01, 8'h3c);
      t_sel();
      t_irq();
      t_reset(1'b1, 1'b0);
      t_rw(8'h80, 8'h96);
      t_irq();
      t_reset(1'b1, 1'b1);
      t_rw(8'h7e, 8'he1);
      t_reset(1'b0, 1'b1);
      t_rw(8'hfe, 8'h0f);
      complete_run();
   end
   // Run needs about 3 us; the margin covers a stuck handshake
   initial begin
      #50us;
      error_cnt++;
      complete_run();
   end
endmodule : tb_cph_host_port
